// >>> logic/mbscfg_consts.svh
`ifndef MBSCFG_CONSTS_SVH
`define MBSCFG_CONSTS_SVH

`define MBSCFG_CLK_HZ        50000000
`define MBSCFG_IDLE_TIME_S   5
`define MBSCFG_IDLE_CYC      (`MBSCFG_IDLE_TIME_S * `MBSCFG_CLK_HZ)
`define MBSCFG_SIL_BITS_X10  385
`define MBSCFG_BAUD_FAST     19200
`define MBSCFG_BAUD_SLOW     9600
`define MBSCFG_SIL_CYC(b)    ((`MBSCFG_SIL_BITS_X10 * (`MBSCFG_CLK_HZ / 100) + (b) / 10 - 1) / ((b) / 10))

`define MBSCFG_DEF_ADDR      8'hFF
`define MBSCFG_MODE_BAUD_BIT 0
`define MBSCFG_MODE_PAR_BIT  7
`define MBSCFG_MODE_RST      8'h00
`define MBSCFG_ADDR_RST      8'h01

`define MBSCFG_NUM_MODE      17'h00112
`define MBSCFG_NUM_ADDR      17'h00113
`define MBSCFG_NUM_ID_FIRST  17'h00101
`define MBSCFG_NUM_ID_LAST   17'h00108
`define MBSCFG_NUM_REG_LAST  17'h00200
`define MBSCFG_NUM_COIL_LAST 17'h0000C

`define MBSCFG_FC_DISC_RD    8'h02
`define MBSCFG_FC_HOLD_RD    8'h03
`define MBSCFG_FC_INP_RD     8'h04
`define MBSCFG_FC_COIL_WR    8'h05
`define MBSCFG_FC_REG_WR     8'h06
`define MBSCFG_FC_MULTI_WR   8'h10
`define MBSCFG_EXC_NONE      8'h00
`define MBSCFG_EXC_FUNC      8'h01
`define MBSCFG_EXC_ADDR      8'h02

`define MBSCFG_CRC_INIT      16'hFFFF
`define MBSCFG_CRC_POLY      16'hA001
`define MBSCFG_MIN_FRAME     8'h04

`define MBSCFG_OFF_MODE      12'h000
`define MBSCFG_OFF_ADDR      12'h004
`define MBSCFG_OFF_STATUS    12'h008
`define MBSCFG_OFF_FRAMES    12'h00C
`define MBSCFG_RESP_OKAY     2'b00
`define MBSCFG_RESP_SLVERR   2'b10

`endif

// >>> logic/mbscfg_pkg.sv
package mbscfg_pkg;
    typedef enum logic [1:0] {
        MBSCFG_MAP_NONE,
        MBSCFG_MAP_COIL,
        MBSCFG_MAP_REG
    } mbscfg_map_t;

    typedef enum logic {
        MBSCFG_FR_IDLE,
        MBSCFG_FR_RX
    } mbscfg_frame_t;

    typedef struct packed {
        mbscfg_map_t map;
        logic        zero;
        logic [7:0]  exc;
        logic [16:0] loc;
    } mbscfg_entry_t;
endpackage : mbscfg_pkg

// >>> logic/mbscfg_top.sv
// The AXI4-Lite register port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`include "mbscfg_consts.svh"
module mbscfg_top #(
    parameter int DEPTH        = 2,
    parameter int IDLE_CYC     = `MBSCFG_IDLE_CYC,
    parameter int SIL_FAST_CYC = `MBSCFG_SIL_CYC(`MBSCFG_BAUD_FAST),
    parameter int SIL_SLOW_CYC = `MBSCFG_SIL_CYC(`MBSCFG_BAUD_SLOW)
) (
    // Clock and reset
    input  wire logic                     clk_i,
    input  wire logic                     reset_i,
    // Jumper and received bytes
    input  wire logic                     default_param_jumper_i,
    input  wire logic                     rx_byte_valid_i,
    input  wire logic [7:0]               rx_byte_i,
    // Decoded request
    input  wire logic                     req_valid_i,
    output logic                          req_ready_o,
    input  wire logic [7:0]               req_func_i,
    input  wire logic [15:0]              req_addr_i,
    input  wire logic [15:0]              req_data_i,
    // Mapped answer
    output logic                          rsp_valid_o,
    input  wire logic                     rsp_ready_i,
    output mbscfg_pkg::mbscfg_map_t       rsp_map_o,
    output logic                          rsp_zero_o,
    output logic [7:0]                    rsp_exc_o,
    output logic [16:0]                   rsp_loc_o,
    // Serial parameters
    output logic                          baud_9600_o,
    output logic                          parity_none_o,
    output logic [7:0]                    slave_addr_o,
    output logic                          default_mode_o,
    output logic                          serial_reset_o,
    output logic                          frame_ok_o,
    // AXI4-Lite slave
    input  wire logic                     s_axi_awvalid,
    output logic                          s_axi_awready,
    input  wire logic [11:0]              s_axi_awaddr,
    input  wire logic                     s_axi_wvalid,
    output logic                          s_axi_wready,
    input  wire logic [31:0]              s_axi_wdata,
    input  wire logic [3:0]               s_axi_wstrb,
    output logic                          s_axi_bvalid,
    input  wire logic                     s_axi_bready,
    output logic [1:0]                    s_axi_bresp,
    input  wire logic                     s_axi_arvalid,
    output logic                          s_axi_arready,
    input  wire logic [11:0]              s_axi_araddr,
    output logic                          s_axi_rvalid,
    input  wire logic                     s_axi_rready,
    output logic [31:0]                   s_axi_rdata,
    output logic [1:0]                    s_axi_rresp
);
    import mbscfg_pkg::*;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);

    function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] b);
        logic [15:0] r;
        r = c ^ {8'h00, b};
        for (int k = 0; k < 8; k++) begin
            r = r[0] ? ((r >> 1) ^ `MBSCFG_CRC_POLY) : (r >> 1);
        end
        return r;
    endfunction : crc_byte

    // Stored and active parameters
    localparam logic [7:0] MODE_RST = `MBSCFG_MODE_RST;
    logic [7:0]    stored_mode_reg;
    logic [7:0]    stored_addr_reg;
    logic [27:0]   idle_cnt_reg;
    logic [27:0]   sil_cnt_reg;
    logic [15:0]   crc_reg;
    logic [7:0]    len_reg;
    logic [15:0]   ok_cnt_reg;
    logic [15:0]   bad_cnt_reg;
    mbscfg_frame_t fr_state_reg;

    // Request decode
    wire [16:0] dec_loc    = {1'b0, req_addr_i} + 17'h00001;
    wire        fc_coil_wr = req_func_i == `MBSCFG_FC_COIL_WR;
    wire        fc_reg_rd  = req_func_i == `MBSCFG_FC_HOLD_RD || req_func_i == `MBSCFG_FC_INP_RD;
    wire        fc_reg_wr  = req_func_i == `MBSCFG_FC_REG_WR || req_func_i == `MBSCFG_FC_MULTI_WR;
    wire        fc_known   = fc_coil_wr || fc_reg_rd || fc_reg_wr;
    wire        coil_ok    = dec_loc <= `MBSCFG_NUM_COIL_LAST;
    wire        reg_in     = dec_loc <= `MBSCFG_NUM_REG_LAST;
    wire        reg_ro     = dec_loc >= `MBSCFG_NUM_ID_FIRST && dec_loc <= `MBSCFG_NUM_ID_LAST;
    wire [7:0]  dec_exc    = !fc_known ? `MBSCFG_EXC_FUNC :
                             fc_coil_wr ? (coil_ok ? `MBSCFG_EXC_NONE : `MBSCFG_EXC_ADDR) :
                             fc_reg_wr ? ((reg_in && !reg_ro) ? `MBSCFG_EXC_NONE
                                                              : `MBSCFG_EXC_ADDR) :
                             `MBSCFG_EXC_NONE;
    wire        dec_zero   = fc_reg_rd && !reg_in;
    mbscfg_map_t dec_map;
    assign dec_map = !fc_known ? MBSCFG_MAP_NONE : (fc_coil_wr ? MBSCFG_MAP_COIL : MBSCFG_MAP_REG);
    wire        req_take   = req_valid_i && req_ready_o;
    wire        cfg_wr     = req_take && req_func_i == `MBSCFG_FC_REG_WR
                             && dec_exc == `MBSCFG_EXC_NONE;
    wire        mb_mode_wr = cfg_wr && dec_loc == `MBSCFG_NUM_MODE;
    wire        mb_addr_wr = cfg_wr && dec_loc == `MBSCFG_NUM_ADDR;

    // Answer buffer, shift form, head is entry 0
    mbscfg_entry_t mem_reg [DEPTH];
    logic [$clog2(DEPTH+1)-1:0] cnt_reg;
    wire  buf_pop  = rsp_valid_o && rsp_ready_i;
    wire [$clog2(DEPTH+1)-1:0] cnt_next = cnt_reg + (req_take ? 1'b1 : 1'b0)
                                          - (buf_pop ? 1'b1 : 1'b0);
    wire [$clog2(DEPTH+1)-1:0] wr_idx   = cnt_reg - (buf_pop ? 1'b1 : 1'b0);
    mbscfg_entry_t new_entry;
    assign new_entry = '{map: dec_map, zero: dec_zero, exc: dec_exc, loc: dec_loc};

    genvar gi;
    generate
        for (gi = 0; gi < DEPTH; gi++) begin : g_ent
            mbscfg_entry_t shifted;
            assign shifted = (buf_pop && gi + 1 < DEPTH) ? mem_reg[(gi + 1) % DEPTH] : mem_reg[gi];
            always_ff @(posedge clk_i or posedge reset_i) begin
                if (reset_i) begin
                    mem_reg[gi] <= '0;
                end else begin
                    mem_reg[gi] <= (req_take && wr_idx == gi) ? new_entry : shifted;
                end
            end
        end
    endgenerate

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            cnt_reg     <= '0;
            rsp_valid_o <= 1'b0;
            req_ready_o <= 1'b0;
        end else begin
            cnt_reg     <= cnt_next;
            rsp_valid_o <= cnt_next != 0;
            req_ready_o <= cnt_next < DEPTH;
        end
    end
    assign rsp_map_o  = mem_reg[0].map;
    assign rsp_zero_o = mem_reg[0].zero;
    assign rsp_exc_o  = mem_reg[0].exc;
    assign rsp_loc_o  = mem_reg[0].loc;

    // Frame boundary and CRC tracking
    wire [27:0] sil_lim   = baud_9600_o ? 28'(SIL_SLOW_CYC - 1) : 28'(SIL_FAST_CYC - 1);
    wire        fr_end    = fr_state_reg == MBSCFG_FR_RX && !rx_byte_valid_i && sil_cnt_reg == sil_lim;
    wire        fr_good   = crc_reg == 16'h0000 && len_reg >= `MBSCFG_MIN_FRAME;
    wire [15:0] crc_seed  = fr_state_reg == MBSCFG_FR_RX ? crc_reg : `MBSCFG_CRC_INIT;
    wire        idle_hit  = idle_cnt_reg == 28'(IDLE_CYC - 1);

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            fr_state_reg <= MBSCFG_FR_IDLE;
            sil_cnt_reg  <= '0;
            crc_reg      <= `MBSCFG_CRC_INIT;
            len_reg      <= '0;
        end else if (rx_byte_valid_i) begin
            fr_state_reg <= MBSCFG_FR_RX;
            sil_cnt_reg  <= '0;
            crc_reg      <= crc_byte(crc_seed, rx_byte_i);
            len_reg      <= fr_state_reg == MBSCFG_FR_RX ? len_reg + (&len_reg ? 8'h00 : 8'h01)
                                                         : 8'h01;
        end else begin
            case (fr_state_reg)
                MBSCFG_FR_RX: begin
                    sil_cnt_reg <= sil_cnt_reg + 28'h0000001;
                    if (fr_end) begin
                        fr_state_reg <= MBSCFG_FR_IDLE;
                    end
                end
                default: sil_cnt_reg <= '0;
            endcase
        end
    end

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            frame_ok_o   <= 1'b0;
            ok_cnt_reg   <= '0;
            bad_cnt_reg  <= '0;
            idle_cnt_reg <= '0;
        end else begin
            frame_ok_o <= fr_end && fr_good;
            if (fr_end && fr_good) begin
                ok_cnt_reg <= ok_cnt_reg + 16'h0001;
            end
            if (fr_end && !fr_good) begin
                bad_cnt_reg <= bad_cnt_reg + 16'h0001;
            end
            idle_cnt_reg <= (frame_ok_o || idle_hit) ? '0 : idle_cnt_reg + 28'h0000001;
        end
    end

    // Active parameter selection
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            baud_9600_o    <= MODE_RST[`MBSCFG_MODE_BAUD_BIT];
            parity_none_o  <= MODE_RST[`MBSCFG_MODE_PAR_BIT];
            slave_addr_o   <= `MBSCFG_ADDR_RST;
            default_mode_o <= 1'b0;
            serial_reset_o <= 1'b0;
        end else begin
            serial_reset_o <= idle_hit && !default_param_jumper_i;
            if (default_param_jumper_i) begin
                baud_9600_o    <= 1'b0;
                parity_none_o  <= 1'b0;
                slave_addr_o   <= `MBSCFG_DEF_ADDR;
                default_mode_o <= 1'b1;
            end else if (idle_hit) begin
                baud_9600_o    <= stored_mode_reg[`MBSCFG_MODE_BAUD_BIT];
                parity_none_o  <= stored_mode_reg[`MBSCFG_MODE_PAR_BIT];
                slave_addr_o   <= stored_addr_reg;
                default_mode_o <= 1'b0;
            end
        end
    end

    // AXI4-Lite slave
    logic [11:0] awaddr_reg;
    logic [31:0] wdata_reg;
    logic        wstrb0_reg;
    wire  aw_take  = s_axi_awvalid && s_axi_awready;
    wire  w_take   = s_axi_wvalid && s_axi_wready;
    wire  wr_go    = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
    wire  wr_mode  = wr_go && awaddr_reg == `MBSCFG_OFF_MODE && wstrb0_reg;
    wire  wr_addr  = wr_go && awaddr_reg == `MBSCFG_OFF_ADDR && wstrb0_reg;
    wire  wr_hit   = awaddr_reg == `MBSCFG_OFF_MODE || awaddr_reg == `MBSCFG_OFF_ADDR;
    wire  ar_take  = s_axi_arvalid && s_axi_arready;
    wire  rd_hit   = s_axi_araddr[11:4] == 8'h00 && s_axi_araddr[1:0] == 2'b00;
    wire [31:0] status_word = {20'h00000, fr_state_reg == MBSCFG_FR_RX, default_mode_o,
                               parity_none_o, baud_9600_o, slave_addr_o};
    wire [31:0] rd_word = s_axi_araddr == `MBSCFG_OFF_MODE   ? {24'h000000, stored_mode_reg} :
                          s_axi_araddr == `MBSCFG_OFF_ADDR   ? {24'h000000, stored_addr_reg} :
                          s_axi_araddr == `MBSCFG_OFF_STATUS ? status_word :
                          s_axi_araddr == `MBSCFG_OFF_FRAMES ? {bad_cnt_reg, ok_cnt_reg} :
                          32'h00000000;

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `MBSCFG_RESP_OKAY;
            awaddr_reg    <= '0;
            wdata_reg     <= '0;
            wstrb0_reg    <= 1'b0;
        end else begin
            if (aw_take) begin
                awaddr_reg    <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (w_take) begin
                wdata_reg    <= s_axi_wdata;
                wstrb0_reg   <= s_axi_wstrb[0];
                s_axi_wready <= 1'b0;
            end
            if (wr_go) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_hit ? `MBSCFG_RESP_OKAY : `MBSCFG_RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= '0;
            s_axi_rresp   <= `MBSCFG_RESP_OKAY;
        end else if (ar_take) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= rd_word;
            s_axi_rresp   <= rd_hit ? `MBSCFG_RESP_OKAY : `MBSCFG_RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
        end
    end

    // Stored configuration, link write wins over bus write
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            stored_mode_reg <= `MBSCFG_MODE_RST;
            stored_addr_reg <= `MBSCFG_ADDR_RST;
        end else begin
            if (mb_mode_wr) begin
                stored_mode_reg <= req_data_i[7:0];
            end else if (wr_mode) begin
                stored_mode_reg <= wdata_reg[7:0];
            end
            if (mb_addr_wr) begin
                stored_addr_reg <= req_data_i[7:0];
            end else if (wr_addr) begin
                stored_addr_reg <= wdata_reg[7:0];
            end
        end
    end

    // Checks
    sequence s_idle_expire;
        idle_hit && !default_param_jumper_i;
    endsequence
    sequence s_stored_applied;
        serial_reset_o && !default_mode_o && slave_addr_o == $past(stored_addr_reg);
    endsequence

    AST_JUMPER_SWITCH: assert property (default_param_jumper_i |=> default_mode_o)
        else $error("jumper did not select defaults");
    AST_JUMPER_VALUES: assert property (default_mode_o |-> slave_addr_o == `MBSCFG_DEF_ADDR
        && !baud_9600_o && !parity_none_o) else $error("default parameters wrong");
    AST_IDLE_RELOAD: assert property (s_idle_expire |=> s_stored_applied)
        else $error("idle expiry did not reload stored parameters");
    AST_MODE_BITS: assert property (s_idle_expire |=> baud_9600_o == $past(stored_mode_reg[0])
        && parity_none_o == $past(stored_mode_reg[7])) else $error("mode bits misapplied");
    AST_HIGH_READ_ZERO: assert property (req_take && fc_reg_rd && req_addr_i >= 16'h0200
        |=> ##[0:8] rsp_valid_o && rsp_zero_o && rsp_exc_o == `MBSCFG_EXC_NONE
        || cnt_reg > 1) else $error("unimplemented read not zero");
    AST_COIL_RANGE: assert property (req_take && fc_coil_wr && req_addr_i > 16'h000B
        |-> dec_exc == `MBSCFG_EXC_ADDR && dec_map == MBSCFG_MAP_COIL)
        else $error("coil outside range accepted");
    AST_DISCRETE_UNSUP: assert property (req_take && req_func_i == `MBSCFG_FC_DISC_RD
        |-> dec_exc == `MBSCFG_EXC_FUNC && dec_map == MBSCFG_MAP_NONE)
        else $error("discrete read not refused");
    AST_PLUS_ONE: assert property (req_take && cnt_reg == 0
        |=> rsp_valid_o && rsp_loc_o == {1'b0, $past(req_addr_i)} + 17'h00001)
        else $error("location is not address plus one");
    AST_STORED_ADDR: assert property (mb_addr_wr |=> stored_addr_reg == $past(req_data_i[7:0]))
        else $error("stored address not written");
    AST_UNSUP_FUNC: assert property (req_take && !fc_known |=> rsp_valid_o)
        else $error("unsupported function produced no answer");
    AST_CRC_GATE: assert property (frame_ok_o |-> $past(crc_reg) == 16'h0000
        && $past(sil_cnt_reg) == $past(sil_lim)) else $error("frame accepted without CRC or gap");
    AST_BUF_HOLD: assert property (rsp_valid_o && !rsp_ready_i |=> rsp_valid_o && $stable(rsp_loc_o))
        else $error("answer dropped under stall");
endmodule : mbscfg_top

// >>> sim/mbscfg_master_model.sv
`timescale 1ns/1ps
module mbscfg_master_model (
    // Clock and control
    input  wire logic       clk_i,
    input  wire logic       send_i,
    input  wire logic       corrupt_i,
    // Byte stream towards the slave
    output logic            rx_byte_valid_o,
    output logic [7:0]      rx_byte_o
);
    logic [7:0]  fr [4];
    logic [15:0] crc;
    initial begin
        rx_byte_valid_o = 1'b0;
        rx_byte_o = 8'h00;
    end
    // Frame: address, read code, CRC low, CRC high
    always @(posedge clk_i) begin
        if (send_i) begin
            fr[0] = 8'h22;
            fr[1] = 8'h03;
            crc = 16'hFFFF;
            for (int i = 0; i < 2; i++) begin
                crc = crc ^ {8'h00, fr[i]};
                for (int k = 0; k < 8; k++) crc = crc[0] ? (crc >> 1) ^ 16'hA001 : crc >> 1;
            end
            fr[2] = crc[7:0] ^ {7'h00, corrupt_i};
            fr[3] = crc[15:8];
            for (int i = 0; i < 4; i++) begin
                rx_byte_valid_o <= 1'b1;
                rx_byte_o <= fr[i];
                @(posedge clk_i);
                rx_byte_valid_o <= 1'b0;
                rx_byte_o <= ~fr[i];
                @(posedge clk_i);
            end
        end
    end
endmodule : mbscfg_master_model

// >>> sim/mbscfg_top_test.sv
`timescale 1ns/1ps
module mbscfg_top_test;
    import mbscfg_pkg::*;
    logic clk_i = 1'b0, reset_i = 1'b1, default_param_jumper_i = 1'b0, send = 1'b0, corrupt = 1'b0;
    logic rx_byte_valid_i, req_valid_i = 1'b0, rsp_ready_i = 1'b0;
    logic [7:0] rx_byte_i, req_func_i = 8'h00, rsp_exc_o, slave_addr_o;
    logic [15:0] req_addr_i = 16'h0000, req_data_i = 16'h0000;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'h0;
    logic req_ready_o, rsp_valid_o, rsp_zero_o, baud_9600_o, parity_none_o, default_mode_o;
    logic serial_reset_o, frame_ok_o, s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [16:0] rsp_loc_o;
    mbscfg_map_t rsp_map_o;
    int err_total = 0, n_checks = 0;
    logic [51:0] tbl [8] = '{
        {8'h03, 16'h0000, 2'h2, 1'b0, 8'h00, 17'h00001},
        {8'h03, 16'h0200, 2'h2, 1'b1, 8'h00, 17'h00201},
        {8'h05, 16'h000B, 2'h1, 1'b0, 8'h00, 17'h0000C},
        {8'h05, 16'h000C, 2'h1, 1'b0, 8'h02, 17'h0000D},
        {8'h02, 16'h0000, 2'h0, 1'b0, 8'h01, 17'h00001},
        {8'h01, 16'h0000, 2'h0, 1'b0, 8'h01, 17'h00001},
        {8'h06, 16'h0100, 2'h2, 1'b0, 8'h02, 17'h00101},
        {8'h04, 16'hFFFF, 2'h2, 1'b1, 8'h00, 17'h10000}};
    always #10 clk_i = ~clk_i;
    mbscfg_top #(.IDLE_CYC(200), .SIL_FAST_CYC(20), .SIL_SLOW_CYC(40)) dut (.clk_i, .reset_i,
        .default_param_jumper_i, .rx_byte_valid_i, .rx_byte_i, .req_valid_i, .req_ready_o,
        .req_func_i, .req_addr_i, .req_data_i, .rsp_valid_o, .rsp_ready_i, .rsp_map_o,
        .rsp_zero_o, .rsp_exc_o, .rsp_loc_o, .baud_9600_o, .parity_none_o, .slave_addr_o,
        .default_mode_o, .serial_reset_o, .frame_ok_o, .s_axi_awvalid, .s_axi_awready,
        .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid,
        .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr,
        .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp);
    mbscfg_master_model u_master (.clk_i, .send_i(send), .corrupt_i(corrupt),
        .rx_byte_valid_o(rx_byte_valid_i), .rx_byte_o(rx_byte_i));
    task finish_test;
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : finish_test
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask : chk
    task hang(input int n);
        if (n >= 300) begin
            chk(32'h0, 32'h1);
            finish_test;
        end
    endtask : hang
    task automatic wait_hi(ref logic s, input int lim);
        int n;
        for (n = 0; n < lim && s !== 1'b1; n++) @(posedge clk_i);
        hang(n >= lim ? 300 : 0);
    endtask : wait_hi
    task axw(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
        int n;
        @(posedge clk_i);
        s_axi_awvalid <= 1'b1;
        s_axi_awaddr <= a;
        s_axi_wvalid <= 1'b1;
        s_axi_wdata <= d;
        s_axi_wstrb <= 4'hF;
        s_axi_bready <= 1'b1;
        for (n = 0; n < 300; n++) begin
            @(posedge clk_i);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) break;
        end
        s_axi_bready <= 1'b0;
        hang(n);
        chk(32'(s_axi_bresp), 32'(er));
    endtask : axw
    task axr(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
        int n;
        @(posedge clk_i);
        s_axi_arvalid <= 1'b1;
        s_axi_araddr <= a;
        s_axi_rready <= 1'b1;
        for (n = 0; n < 300; n++) begin
            @(posedge clk_i);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) break;
        end
        s_axi_rready <= 1'b0;
        hang(n);
        chk(s_axi_rdata, ed);
        chk(32'(s_axi_rresp), 32'(er));
    endtask : axr
    task req(input logic [7:0] f, input logic [15:0] a, input logic [15:0] d);
        int n;
        @(posedge clk_i);
        req_valid_i <= 1'b1;
        req_func_i <= f;
        req_addr_i <= a;
        req_data_i <= d;
        for (n = 0; n < 300; n++) begin
            @(posedge clk_i);
            if (req_ready_o === 1'b1) break;
        end
        req_valid_i <= 1'b0;
        hang(n);
    endtask : req
    task rsp(input logic [27:0] e);
        int n;
        @(posedge clk_i);
        rsp_ready_i <= 1'b1;
        for (n = 0; n < 300; n++) begin
            @(posedge clk_i);
            if (rsp_valid_o === 1'b1) break;
        end
        rsp_ready_i <= 1'b0;
        hang(n);
        chk(32'({rsp_map_o, rsp_zero_o, rsp_exc_o, rsp_loc_o}), 32'(e));
    endtask : rsp
    task t_decode;
        req(tbl[0][51:44], tbl[0][43:28], 16'h0000);
        req(tbl[1][51:44], tbl[1][43:28], 16'h0000);
        repeat (2) @(posedge clk_i);
        chk(32'(req_ready_o), 32'h0);
        for (int i = 0; i < 8; i++) begin
            if (i > 1) req(tbl[i][51:44], tbl[i][43:28], 16'h0000);
            rsp(tbl[i][27:0]);
        end
        req(8'h10, 16'h01FF, 16'h0000);
        rsp({2'h2, 1'b0, 8'h00, 17'h00200});
        req(8'h10, 16'h0200, 16'h0000);
        rsp({2'h2, 1'b0, 8'h02, 17'h00201});
        $display("decode test done");
    endtask : t_decode
    task t_config;
        req(8'h06, 16'h0111, 16'h0081);
        rsp({2'h2, 1'b0, 8'h00, 17'h00112});
        req(8'h06, 16'h0112, 16'h0022);
        rsp({2'h2, 1'b0, 8'h00, 17'h00113});
        axr(12'h000, 32'h81, 2'b00);
        axr(12'h004, 32'h22, 2'b00);
        wait_hi(serial_reset_o, 250);
        chk(32'({baud_9600_o, parity_none_o, slave_addr_o}), 32'h322);
        axw(12'h000, 32'h01, 2'b00);
        axw(12'h008, 32'h0, 2'b10);
        axr(12'h010, 32'h0, 2'b10);
        @(posedge clk_i);
        wait_hi(serial_reset_o, 250);
        chk(32'({baud_9600_o, parity_none_o, slave_addr_o}), 32'h222);
        axr(12'h008, 32'h122, 2'b00);
        $display("config test done");
    endtask : t_config
    task t_jumper;
        @(posedge clk_i);
        default_param_jumper_i <= 1'b1;
        wait_hi(default_mode_o, 10);
        chk(32'({baud_9600_o, parity_none_o, slave_addr_o}), 32'h0FF);
        default_param_jumper_i <= 1'b0;
        @(posedge clk_i);
        wait_hi(serial_reset_o, 250);
        chk(32'({default_mode_o, slave_addr_o}), 32'h022);
        $display("jumper test done");
    endtask : t_jumper
    task t_frames;
        int seen;
        @(posedge clk_i);
        send <= 1'b1;
        @(posedge clk_i);
        send <= 1'b0;
        wait_hi(frame_ok_o, 150);
        @(posedge clk_i);
        send <= 1'b1;
        corrupt <= 1'b1;
        @(posedge clk_i);
        send <= 1'b0;
        seen = 0;
        repeat (150) @(posedge clk_i) seen += frame_ok_o;
        chk(32'(seen), 32'h0);
        axr(12'h00C, 32'h00010001, 2'b00);
        $display("frame test done");
    endtask : t_frames
    initial begin
        repeat (3) @(posedge clk_i);
        reset_i <= 1'b0;
        axr(12'h000, 32'h0, 2'b00);
        axr(12'h004, 32'h1, 2'b00);
        chk(32'({default_mode_o, slave_addr_o}), 32'h001);
        $display("reset test done");
        t_decode;
        t_config;
        t_jumper;
        t_frames;
        finish_test;
    end
endmodule : mbscfg_top_test
